/* rtl/afb_pkg.sv */
// constants, enumerations and carriers shared by the api output frame builder
package afb_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DEST_HI = 8'h04;
  localparam logic [7:0] OFF_DEST_LO = 8'h08;
  localparam logic [7:0] OFF_AGG_HI = 8'h0c;
  localparam logic [7:0] OFF_AGG_LO = 8'h10;
  localparam logic [7:0] OFF_SRC_HI = 8'h14;
  localparam logic [7:0] OFF_SRC_LO = 8'h18;
  localparam logic [7:0] OFF_RX_GO = 8'h1c;
  localparam logic [7:0] OFF_CHR = 8'h20;
  localparam logic [7:0] OFF_CMD_GO = 8'h24;
  localparam logic [7:0] OFF_PAY_LEN = 8'h28;
  localparam logic [7:0] OFF_PAYLOAD = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AGG_BIT = 1;
  localparam int CTRL_AO_LSB = 8;
  localparam logic EN_RST = 1'b0;
  localparam logic [7:0] AO_RST = 8'h00;
  localparam logic [63:0] DEST_RST = 64'h0;

  // ---------------------------------------------------------------
  // frame encoding
  // ---------------------------------------------------------------
  localparam logic [7:0] DELIM = 8'h7e;
  localparam logic [7:0] TYPE_UPD = 8'h8e;
  localparam logic [7:0] TYPE_RX = 8'h80;
  localparam logic [7:0] TYPE_CMD = 8'h88;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  localparam logic [7:0] REQ_LOCAL = 8'h08;
  localparam logic [7:0] REQ_QUEUED = 8'h09;
  localparam logic [7:0] AO_LEGACY = 8'h02;
  localparam logic [15:0] SHORT_ADDR64 = 16'hfffe;
  localparam logic [7:0] OPT_MASK = 8'h06;
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_ERR = 2'h1;
  localparam logic [1:0] ST_BADCMD = 2'h2;
  localparam logic [1:0] ST_BADPAR = 2'h3;

  // frame offsets and body lengths
  localparam logic [8:0] OFF_LEN_HI = 9'h001;
  localparam logic [8:0] OFF_LEN_LO = 9'h002;
  localparam logic [8:0] OFF_TYPE = 9'h003;
  localparam logic [8:0] OFF_RSVD = 9'h004;
  localparam logic [8:0] OFF_NEW = 9'h005;
  localparam logic [8:0] OFF_OLD = 9'h00d;
  localparam logic [8:0] OFF_RXSRC = 9'h004;
  localparam logic [8:0] OFF_RSSI = 9'h00c;
  localparam logic [8:0] OFF_OPT = 9'h00d;
  localparam logic [8:0] OFF_ID = 9'h004;
  localparam logic [8:0] OFF_CHR_HI = 9'h005;
  localparam logic [8:0] OFF_CHR_LO = 9'h006;
  localparam logic [8:0] OFF_STAT = 9'h007;
  localparam logic [8:0] HDR_UPD = 9'h015;
  localparam logic [8:0] HDR_RX = 9'h00e;
  localparam logic [8:0] HDR_CMD = 9'h008;
  localparam logic [8:0] LEN_UPD = 9'h012;
  localparam logic [8:0] LEN_RX_BASE = 9'h00b;
  localparam logic [8:0] LEN_CMD_BASE = 9'h005;

  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {KIND_UPD, KIND_RX, KIND_CMD} afb_kind_e;
  typedef enum logic [1:0] {S_IDLE, S_SEND, S_DRAIN} afb_fsm_e;

  typedef struct packed {
    logic [63:0] new_addr;
    logic [63:0] old_addr;
  } afb_upd_s;

endpackage

/* rtl/afb_fifo.sv */
// parameterised fifo with valid/ready on both sides
`timescale 1ns/10ps
module afb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic ce, // clock enable
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [W-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // read accept
  output logic [W-1:0] out_data // head of queue
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } afb_fifo_s;

  afb_fifo_s q;
  afb_fifo_s d;
  logic [W-1:0] mem [D];
  logic push;

  assign in_ready = !(q.wp[AW] != q.rp[AW] && q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign out_valid = q.wp != q.rp;
  assign out_data = mem[q.rp[AW-1:0]];
  assign push = in_valid && in_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
      if (push) begin
        mem[q.wp[AW-1:0]] <= in_data;
      end
    end
  end
endmodule

/* rtl/afb_dest.sv */
// destination address holder and aggregator update matcher
`timescale 1ns/10ps
module afb_dest (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic ce, // clock enable
  input wire logic agg_on, // aggregator support issued
  input wire logic [63:0] agg_addr, // address of aggregator node
  input wire logic sw_wr_hi, // software write of upper word
  input wire logic sw_wr_lo, // software write of lower word
  input wire logic [31:0] sw_data, // software write data
  input wire logic upd_valid, // incoming addressing update
  output logic upd_ready, // update taken
  input wire logic [63:0] upd_src, // node that sent the update
  input wire logic [63:0] upd_match, // address named in update
  input wire logic [63:0] upd_new, // address to adopt
  output logic [63:0] dest, // current destination address
  output logic pend, // notice frame waiting
  output afb_pkg::afb_upd_s upd, // new and old addresses
  input wire logic ack // notice frame started
);
  typedef struct packed {
    logic [63:0] dest;
    logic pend;
    afb_pkg::afb_upd_s ev;
  } afb_dest_s;

  afb_dest_s q;
  afb_dest_s d;

  assign upd_ready = !q.pend;
  assign dest = q.dest;
  assign pend = q.pend;
  assign upd = q.ev;

  always_comb begin
    d = q;
    if (sw_wr_hi) begin
      d.dest[63:32] = sw_data;
    end
    if (sw_wr_lo) begin
      d.dest[31:0] = sw_data;
    end
    if (ack) begin
      d.pend = 1'b0;
    end
    // updates not from the aggregator or not naming us are consumed silently
    if (upd_valid && !q.pend && agg_on && upd_src == agg_addr) begin
      if (q.dest == upd_match) begin
        d.dest = upd_new;
        d.pend = 1'b1;
        d.ev.new_addr = upd_new;
        d.ev.old_addr = q.dest;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.dest <= afb_pkg::DEST_RST;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule

/* rtl/afb_frame_builder.sv */
// api output frame builder: ahb-lite registers, frame engine, byte stream out
`timescale 1ns/10ps

// How it works
// - Frame opens with delimiter, then 16-bit count of bytes from offset 3 up to the checksum.
// - Checksum is 0xff minus low byte of sum from offset 3 on.
// - Update frame carries type 0x8e and a zero reserved byte at offset 4.
// - Update frame holds new address at offset 5, old address at 13.
// - Update naming our destination replaces it and emits the notice frame.
// - Only updates from the node with aggregator support enabled count.
// - Legacy receive frame only with output option 2 and short address 0xfffe.
// - Receive frame: type 0x80, source 4, strength 12, options 13, payload 14.
// - Strength byte is the unsigned magnitude of the negative dBm level.
// - Options: bit0 reserved, bit1 broadcast, bit2 all-PAN broadcast, combinable.
// - Command response answers request types 0x08 and 0x09 only.
// - Zero frame identifier suppresses the command response.
// - Status byte: 0 ok, 1 error, 2 unknown command, 3 bad parameter.
// - Response echoes request frame identifier at offset 4.
module afb_frame_builder (
  input wire logic ref_clk, // clock, 200 MHz
  input wire logic sys_rst, // sync reset, active high
  input wire logic ce, // clock enable, freezes all state
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  output logic [31:0] hrdata, // ahb read data
  input wire logic upd_valid, // addressing update arrives
  output logic upd_ready, // addressing update taken
  input wire logic [63:0] upd_src, // node sending the update
  input wire logic [63:0] upd_match, // address named in update
  input wire logic [63:0] upd_new, // address to adopt
  output logic tx_valid, // frame byte valid
  input wire logic tx_ready, // host link takes byte
  output logic [7:0] tx_data // frame byte
);
  typedef struct packed {
    afb_pkg::afb_fsm_e st;
    afb_pkg::afb_kind_e kind;
    logic [8:0] idx;
    logic [8:0] len;
    logic [7:0] pl;
    logic [7:0] sum;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [63:0] fa;
    logic [63:0] fb;
    logic [31:0] ff;
    logic en;
    logic agg_on;
    logic [7:0] ao;
    logic [63:0] agg;
    logic [63:0] src;
    logic [15:0] chr;
    logic [7:0] pay_len;
    logic sw_pend;
    afb_pkg::afb_kind_e sw_kind;
    logic [7:0] sw_type;
    logic [7:0] sw_len;
    logic [63:0] sw_a;
    logic [31:0] sw_f;
    logic wsel;
    logic [7:0] waddr;
    logic [31:0] rdata;
    logic [7:0] sent;
    logic [7:0] dropped;
  } afb_state_s;

  afb_state_s q;
  afb_state_s d;

  logic acc;
  logic stall;
  logic wfire;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic pop;
  logic upd_ack;
  logic upd_pend;
  afb_pkg::afb_upd_s upd;
  logic [63:0] dest;
  logic last;
  logic pay;
  logic ok;
  logic [7:0] b;

  // ---------------------------------------------------------------
  // byte selection helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] byte64(input logic [63:0] a, input logic [8:0] o,
                                         input logic [8:0] base);
    logic [8:0] k;
    k = o - base;
    byte64 = a[{~k[2:0], 3'b000} +: 8];
  endfunction

  function automatic logic [8:0] hdr_end(input afb_pkg::afb_kind_e k);
    unique case (k)
      afb_pkg::KIND_UPD: hdr_end = afb_pkg::HDR_UPD;
      afb_pkg::KIND_RX: hdr_end = afb_pkg::HDR_RX;
      default: hdr_end = afb_pkg::HDR_CMD;
    endcase
  endfunction

  function automatic logic [7:0] body_byte(input afb_pkg::afb_kind_e k, input logic [8:0] o,
                                            input logic [63:0] a, input logic [63:0] bb,
                                            input logic [31:0] f);
    body_byte = 8'h00;
    unique case (k)
      afb_pkg::KIND_UPD: begin
        if (o == afb_pkg::OFF_TYPE) begin
          body_byte = afb_pkg::TYPE_UPD;
        end else if (o == afb_pkg::OFF_RSVD) begin
          body_byte = afb_pkg::RSVD_BYTE;
        end else if (o < afb_pkg::OFF_OLD) begin
          body_byte = byte64(a, o, afb_pkg::OFF_NEW);
        end else begin
          body_byte = byte64(bb, o, afb_pkg::OFF_OLD);
        end
      end
      afb_pkg::KIND_RX: begin
        if (o == afb_pkg::OFF_TYPE) begin
          body_byte = afb_pkg::TYPE_RX;
        end else if (o < afb_pkg::OFF_RSSI) begin
          body_byte = byte64(a, o, afb_pkg::OFF_RXSRC);
        end else if (o == afb_pkg::OFF_RSSI) begin
          body_byte = f[31:24];
        end else begin
          body_byte = f[23:16];
        end
      end
      default: begin
        if (o == afb_pkg::OFF_TYPE) begin
          body_byte = afb_pkg::TYPE_CMD;
        end else if (o == afb_pkg::OFF_ID) begin
          body_byte = f[31:24];
        end else if (o == afb_pkg::OFF_CHR_HI) begin
          body_byte = f[23:16];
        end else if (o == afb_pkg::OFF_CHR_LO) begin
          body_byte = f[15:8];
        end else begin
          body_byte = f[7:0];
        end
      end
    endcase
  endfunction

  // ---------------------------------------------------------------
  // payload fifo and destination address
  // ---------------------------------------------------------------
  afb_fifo #(
    .W(afb_pkg::FIFO_W),
    .D(afb_pkg::FIFO_D)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(q.wsel && q.waddr == afb_pkg::OFF_PAYLOAD),
    .in_ready(fifo_in_ready),
    .in_data(hwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  afb_dest u_dest (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .agg_on(q.agg_on),
    .agg_addr(q.agg),
    .sw_wr_hi(wfire && q.waddr == afb_pkg::OFF_DEST_HI),
    .sw_wr_lo(wfire && q.waddr == afb_pkg::OFF_DEST_LO),
    .sw_data(hwdata),
    .upd_valid(upd_valid),
    .upd_ready(upd_ready),
    .upd_src(upd_src),
    .upd_match(upd_match),
    .upd_new(upd_new),
    .dest(dest),
    .pend(upd_pend),
    .upd(upd),
    .ack(upd_ack)
  );

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // a payload write stalls the bus while the fifo is full
  assign stall = q.wsel && q.waddr == afb_pkg::OFF_PAYLOAD && !fifo_in_ready;
  assign acc = hsel && htrans[1] && hready && hsize == 3'h2;
  assign wfire = q.wsel && !stall;
  assign hreadyout = !stall;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign tx_valid = q.tx_valid;
  assign tx_data = q.tx_data;

  always_comb begin
    d = q;
    pop = 1'b0;
    upd_ack = 1'b0;
    last = 1'b0;
    pay = 1'b0;
    ok = 1'b0;
    b = 8'h00;

    // -------------------------------------------------------------
    // register access
    // -------------------------------------------------------------
    d.wsel = stall || (acc && hwrite);
    if (!stall) begin
      d.waddr = haddr[7:0];
    end
    if (acc && !hwrite) begin
      case (haddr[7:0])
        afb_pkg::OFF_CTRL: d.rdata = {16'h0, q.ao, 6'h0, q.agg_on, q.en};
        afb_pkg::OFF_DEST_HI: d.rdata = dest[63:32];
        afb_pkg::OFF_DEST_LO: d.rdata = dest[31:0];
        afb_pkg::OFF_AGG_HI: d.rdata = q.agg[63:32];
        afb_pkg::OFF_AGG_LO: d.rdata = q.agg[31:0];
        afb_pkg::OFF_SRC_HI: d.rdata = q.src[63:32];
        afb_pkg::OFF_SRC_LO: d.rdata = q.src[31:0];
        afb_pkg::OFF_CHR: d.rdata = {16'h0, q.chr};
        afb_pkg::OFF_PAY_LEN: d.rdata = {24'h0, q.pay_len};
        afb_pkg::OFF_STATUS: d.rdata = {8'h0, q.dropped, q.sent, 4'h0, !fifo_out_valid,
                                        upd_pend, q.sw_pend, q.st != afb_pkg::S_IDLE};
        default: d.rdata = 32'h0;
      endcase
    end
    if (wfire) begin
      case (q.waddr)
        afb_pkg::OFF_CTRL: begin
          d.en = hwdata[afb_pkg::CTRL_EN_BIT];
          d.agg_on = hwdata[afb_pkg::CTRL_AGG_BIT];
          d.ao = hwdata[afb_pkg::CTRL_AO_LSB +: 8];
        end
        afb_pkg::OFF_AGG_HI: d.agg[63:32] = hwdata;
        afb_pkg::OFF_AGG_LO: d.agg[31:0] = hwdata;
        afb_pkg::OFF_SRC_HI: d.src[63:32] = hwdata;
        afb_pkg::OFF_SRC_LO: d.src[31:0] = hwdata;
        afb_pkg::OFF_CHR: d.chr = hwdata[15:0];
        afb_pkg::OFF_PAY_LEN: d.pay_len = hwdata[7:0];
        afb_pkg::OFF_RX_GO: begin
          if (!q.sw_pend) begin
            d.sw_pend = 1'b1;
            d.sw_kind = afb_pkg::KIND_RX;
            d.sw_a = q.src;
            d.sw_len = q.pay_len;
            d.sw_f[31:24] = 8'h00 - hwdata[7:0];
            d.sw_f[23:16] = hwdata[15:8] & afb_pkg::OPT_MASK;
            d.sw_f[15:0] = hwdata[31:16];
          end
        end
        afb_pkg::OFF_CMD_GO: begin
          if (!q.sw_pend) begin
            d.sw_pend = 1'b1;
            d.sw_kind = afb_pkg::KIND_CMD;
            d.sw_type = hwdata[15:8];
            d.sw_len = q.pay_len;
            d.sw_f = {hwdata[7:0], q.chr, 6'h0, hwdata[17:16]};
          end
        end
        default: d.rdata = q.rdata;
      endcase
    end

    // -------------------------------------------------------------
    // frame engine
    // -------------------------------------------------------------
    if (tx_ready) begin
      d.tx_valid = 1'b0;
    end
    unique case (q.st)
      afb_pkg::S_IDLE: begin
        d.idx = 9'h000;
        d.sum = 8'h00;
        if (q.en && upd_pend) begin
          upd_ack = 1'b1;
          d.kind = afb_pkg::KIND_UPD;
          d.fa = upd.new_addr;
          d.fb = upd.old_addr;
          d.len = afb_pkg::LEN_UPD;
          d.pl = 8'h00;
          d.st = afb_pkg::S_SEND;
        end else if (q.en && q.sw_pend) begin
          d.sw_pend = 1'b0;
          d.kind = q.sw_kind;
          d.fa = q.sw_a;
          d.ff = q.sw_f;
          d.pl = q.sw_len;
          if (q.sw_kind == afb_pkg::KIND_RX) begin
            d.len = afb_pkg::LEN_RX_BASE + {1'b0, q.sw_len};
            ok = q.ao == afb_pkg::AO_LEGACY && q.sw_f[15:0] == afb_pkg::SHORT_ADDR64;
          end else begin
            d.len = afb_pkg::LEN_CMD_BASE + {1'b0, q.sw_len};
            ok = q.sw_f[31:24] != 8'h00 &&
                 (q.sw_type == afb_pkg::REQ_LOCAL || q.sw_type == afb_pkg::REQ_QUEUED);
          end
          // refused frames still consume their payload bytes
          d.st = ok ? afb_pkg::S_SEND : afb_pkg::S_DRAIN;
        end
      end
      afb_pkg::S_SEND: begin
        if (!q.tx_valid || tx_ready) begin
          last = q.idx == q.len + afb_pkg::OFF_TYPE;
          pay = q.idx >= hdr_end(q.kind) && !last;
          if (q.idx == 9'h000) begin
            b = afb_pkg::DELIM;
          end else if (q.idx == afb_pkg::OFF_LEN_HI) begin
            b = {7'h00, q.len[8]};
          end else if (q.idx == afb_pkg::OFF_LEN_LO) begin
            b = q.len[7:0];
          end else if (last) begin
            b = ~q.sum;
          end else if (pay) begin
            b = fifo_out_data;
          end else begin
            b = body_byte(q.kind, q.idx, q.fa, q.fb, q.ff);
          end
          if (!pay || fifo_out_valid) begin
            pop = pay;
            d.tx_valid = 1'b1;
            d.tx_data = b;
            d.idx = q.idx + 1'b1;
            if (q.idx >= afb_pkg::OFF_TYPE) begin
              d.sum = q.sum + b;
            end
            if (last) begin
              d.st = afb_pkg::S_IDLE;
              d.sent = q.sent + 1'b1;
            end
          end
        end
      end
      afb_pkg::S_DRAIN: begin
        if (q.idx == {1'b0, q.pl}) begin
          d.st = afb_pkg::S_IDLE;
          d.dropped = q.dropped + 1'b1;
        end else if (fifo_out_valid) begin
          pop = 1'b1;
          d.idx = q.idx + 1'b1;
        end
      end
      default: d.st = afb_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.en <= afb_pkg::EN_RST;
      q.ao <= afb_pkg::AO_RST;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule

/* tb/afb_frame_builder_asserts.sv */
// assertions on the frame byte stream of the frame builder
`timescale 1ns/10ps
module afb_frame_builder_asserts (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic tx_valid, // byte valid
  input wire logic tx_ready, // byte taken
  input wire logic [7:0] tx_data // frame byte
);
  logic [8:0] pos_q;
  logic [8:0] len_q;
  logic [7:0] sum_q;
  logic [7:0] typ_q;
  logic beat;
  logic last;
  assign beat = ce && tx_valid && tx_ready;
  assign last = pos_q > 9'h002 && pos_q == len_q + 9'h003;
  // position, length, type and running sum of the frame in flight
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pos_q <= 9'h000;
      len_q <= 9'h000;
      sum_q <= 8'h00;
      typ_q <= 8'h00;
    end else if (beat) begin
      pos_q <= last ? 9'h000 : pos_q + 9'h001;
      if (pos_q == 9'h001) len_q <= {tx_data[0], 8'h00};
      if (pos_q == 9'h002) len_q <= {len_q[8], tx_data};
      sum_q <= pos_q > 9'h002 ? sum_q + tx_data : 8'h00;
      if (pos_q == 9'h003) typ_q <= tx_data;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_delim_first: assert property (beat && pos_q == 9'h000 |-> tx_data == 8'h7e)
    else $error("delimiter missing");
  a_len_high: assert property (beat && pos_q == 9'h001 |-> tx_data[7:1] == 7'h00)
    else $error("length high byte wrong");
  a_sum_byte: assert property (beat && last |-> tx_data == 8'hff - sum_q)
    else $error("checksum wrong");
  a_type_code: assert property (beat && pos_q == 9'h003 |-> tx_data inside {8'h8e, 8'h80, 8'h88})
    else $error("type code wrong");
  a_upd_len: assert property (beat && pos_q == 9'h003 && tx_data == 8'h8e |-> len_q == 9'h012)
    else $error("update length wrong");
  a_upd_rsvd: assert property (beat && pos_q == 9'h004 && typ_q == 8'h8e |-> tx_data == 8'h00)
    else $error("reserved byte not zero");
  a_rx_options: assert property (beat && pos_q == 9'h00d && typ_q == 8'h80 |-> !(tx_data & 8'hf9))
    else $error("options byte wrong");
  a_cmd_id: assert property (beat && pos_q == 9'h004 && typ_q == 8'h88 |-> tx_data != 8'h00)
    else $error("response with zero id");
  a_cmd_status: assert property (beat && pos_q == 9'h007 && typ_q == 8'h88 |-> tx_data < 8'h04)
    else $error("status out of range");
  a_byte_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped while stalled");
endmodule

/* tb/afb_host_model.sv */
// host side sink for the frame byte stream: prompt, slow or stalled
`timescale 1ns/10ps
module afb_host_model (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // sync reset
  input wire logic [1:0] mode, // 0 prompt, 1 slow, 2 stalled
  output logic tx_ready // byte accept
);
  logic [1:0] cnt_q;
  always_ff @(posedge ref_clk) cnt_q <= sys_rst ? 2'h0 : cnt_q + 2'h1;
  // slow mode takes one byte in four
  assign tx_ready = !sys_rst && (mode == 2'h0 || (mode == 2'h1 && cnt_q == 2'h0));
endmodule

/* tb/afb_frame_builder_tb_top.sv */
// self-checking bench for the api output frame builder
`timescale 1ns/10ps
module afb_frame_builder_tb_top;
  localparam logic [63:0] ADR_A = 64'h0a1b2c3d_4052aaaa;
  localparam logic [63:0] ADR_N = 64'h0a1b2c3d_4052bbbb;
  localparam logic [63:0] ADR_G = 64'h0a1b2c3d_4052cccc;
  logic ref_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, upd_valid = 1'b0;
  logic rd_dp = 1'b0, saw_stall = 1'b0, hready, hreadyout, upd_ready, tx_valid, tx_ready, hresp;
  logic [1:0] htrans = 2'h0, mode = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rv, hrdata;
  logic [63:0] upd_src = 64'h0, upd_match = 64'h0, upd_new = 64'h0;
  logic [7:0] rs = 8'h28, tx_data;
  logic [31:0] rd_q[$], mk_q[$];
  logic [7:0] tx_q[$], fb[$];
  int n_errors = 0;
  int n_compared = 0;
  assign hready = hreadyout;
  always #2.5 ref_clk = ~ref_clk;
  afb_frame_builder dut_u (.ref_clk, .sys_rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .upd_valid, .upd_ready,
    .upd_src, .upd_match, .upd_new, .tx_valid, .tx_ready, .tx_data);
  afb_host_model host_u (.ref_clk, .sys_rst, .mode, .tx_ready);
  function automatic logic [7:0] rnd();
    rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
    return rs;
  endfunction
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk8(input logic [7:0] e, input logic [7:0] s);
    chk32("tx_data", {24'h0, e}, {24'h0, s});
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hready !== 1'b1 && k++ < 500);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1 && k++ < 500);
    rv = hrdata;
    chk32("hresp", 32'h0, {31'h0, hresp});
    if (k > 500) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back(e);
    mk_q.push_back(m);
    ahb(1'b0, a, 32'h0);
  endtask
  // polls status until the engine is quiet and every expected byte has gone
  task automatic idle();
    int k;
    for (k = 0; k < 300; k++) begin
      rd(8'h30, 32'h0, 32'h0);
      if (rv[2:0] === 3'h0 && tx_q.size() == 0) break;
    end
    if (k == 300) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic frame(input logic [7:0] ty);
    logic [8:0] n;
    logic [7:0] s;
    n = 9'(fb.size() + 1);
    s = 8'hff - ty;
    tx_q.push_back(8'h7e);
    tx_q.push_back({7'h0, n[8]});
    tx_q.push_back(n[7:0]);
    tx_q.push_back(ty);
    foreach (fb[k]) begin
      tx_q.push_back(fb[k]);
      s -= fb[k];
    end
    tx_q.push_back(s);
    fb.delete();
  endtask
  task automatic put64(input logic [63:0] d);
    for (int k = 56; k >= 0; k -= 8) fb.push_back(d[k+:8]);
  endtask
  task automatic upd(input logic [63:0] s, input logic [63:0] m, input logic [63:0] nw);
    int k;
    k = 0;
    upd_src <= s;
    upd_match <= m;
    upd_new <= nw;
    upd_valid <= 1'b1;
    do @(posedge ref_clk); while (upd_ready !== 1'b1 && k++ < 500);
    if (k > 500) begin
      n_errors++;
      give_verdict();
    end
    upd_valid <= 1'b0;
    upd_src <= ~s;
    upd_match <= ~m;
    upd_new <= ~nw;
    idle();
  endtask
  always @(posedge ref_clk) begin
    if (hready) begin
      if (rd_dp) chk32("hrdata", rd_q.pop_front(), hrdata & mk_q.pop_front());
      rd_dp <= hsel && htrans[1] && !hwrite;
    end
    if (!hreadyout) saw_stall <= 1'b1;
    if (tx_valid && tx_ready) begin
      if (tx_q.size() == 0) begin
        n_errors++;
        $display("ERROR tx_data expected none seen %h", tx_data);
      end else chk8(tx_q.pop_front(), tx_data);
    end
  end
  initial begin
    logic [7:0] m, o, n, id, t;
    logic [15:0] c;
    logic [7:0] pl[$];
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    hsel <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00, 32'h0, 32'hffffffff);
    rd(8'h04, 32'h0, 32'hffffffff);
    rd(8'h3c, 32'h0, 32'hffffffff);
    ahb(1'b1, 8'h00, 32'h203);
    ahb(1'b1, 8'h04, ADR_A[63:32]);
    ahb(1'b1, 8'h08, ADR_A[31:0]);
    ahb(1'b1, 8'h0c, ADR_G[63:32]);
    ahb(1'b1, 8'h10, ADR_G[31:0]);
    fb.push_back(8'h00);
    put64(ADR_N);
    put64(ADR_A);
    frame(8'h8e);
    upd(ADR_G, ADR_A, ADR_N);
    rd(8'h04, ADR_N[63:32], 32'hffffffff);
    upd(ADR_A, ADR_N, ADR_A);
    upd(ADR_G, ADR_A, ADR_G);
    ahb(1'b1, 8'h00, 32'h201);
    upd(ADR_G, ADR_N, ADR_A);
    rd(8'h08, ADR_N[31:0], 32'hffffffff);
    ahb(1'b1, 8'h14, ADR_A[63:32]);
    ahb(1'b1, 8'h18, ADR_A[31:0]);
    for (int i = 0; i < 7; i++) begin
      m = rnd() & 8'h7f;
      o = rnd();
      n = i == 6 ? 8'h28 : rnd() & 8'h0f;
      pl.delete();
      repeat (n) pl.push_back(rnd());
      ahb(1'b1, 8'h00, i == 4 ? 32'h103 : 32'h203);
      ahb(1'b1, 8'h28, {24'h0, n});
      if (i != 2 && i != 4) begin
        put64(ADR_A);
        fb.push_back(m);
        fb.push_back(o & 8'h06);
        fb = {fb, pl};
        frame(8'h80);
      end
      mode <= i == 6 ? 2'h2 : {1'b0, i[0]};
      ahb(1'b1, 8'h1c, {i == 2 ? 16'h1234 : 16'hfffe, o, 8'h00 - m});
      fork
        foreach (pl[k]) ahb(1'b1, 8'h2c, {24'h0, pl[k]});
        begin
          for (int k = 0; k < 900 && mode == 2'h2 && !saw_stall; k++) @(posedge ref_clk);
          if (mode == 2'h2) mode <= 2'h1;
        end
      join
      idle();
    end
    chk32("saw_stall", 32'h1, {31'h0, saw_stall});
    mode <= 2'h0;
    ahb(1'b1, 8'h28, 32'h0);
    for (int j = 0; j < 10; j++) begin
      t = j < 4 || j == 9 ? 8'h08 : j < 8 ? 8'h09 : 8'h10;
      id = j == 9 ? 8'h00 : rnd() | 8'h01;
      c = {rnd(), rnd()};
      ahb(1'b1, 8'h20, {16'h0, c});
      if (j < 8) begin
        fb = {id, c[15:8], c[7:0], 8'(j % 4)};
        frame(8'h88);
      end
      ahb(1'b1, 8'h24, {14'h0, 2'(j % 4), t, id});
      idle();
    end
    rd(8'h30, 32'h00040e08, 32'hffffffff);
    give_verdict();
  end
endmodule
bind afb_frame_builder afb_frame_builder_asserts chk_u (.ref_clk, .sys_rst, .ce, .tx_valid,
  .tx_ready, .tx_data);
